// File: bench/ffr_host_model.sv
// host logic: one flash command per go pulse
// assumes go is a one-cycle pulse just after mclk rises
`timescale 1ns/100ps
`default_nettype none
module ffr_host_model (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // request from the bench
  input  wire logic              go,
  input  wire ffr_pkg::ffr_cmd_e kind,
  input  wire logic [7:0]        freq,
  // design side, and idle back to the bench
  input  wire logic [7:0]        statusWord,
  output var  logic              cmdValid,
  output var  ffr_pkg::ffr_cmd_e cmdKind,
  output var  logic              freqWrite,
  output var  logic [7:0]        freqSet,
  output var  logic              idle
);
  import ffr_pkg::*;
  // range load, command pulse, then wait for two ready rises
  initial begin
    {cmdValid, freqWrite, idle, freqSet} = 11'h107;
    cmdKind = CMD_NONE;
    forever begin
      @(posedge mclk);
      if (go && !srst) begin
        #1 idle = 0;
        freqWrite = 1;
        freqSet = freq;
        @(posedge mclk) #1 freqWrite = 0;
        freqSet = ~freq; // released value is not held
        cmdValid = 1;
        cmdKind = kind;
        @(posedge mclk) #1 cmdValid = 0;
        cmdKind = CMD_NONE;
        @(posedge mclk iff statusWord[0]);
        @(posedge mclk iff !statusWord[0]);
        @(posedge mclk iff statusWord[0]);
        #1 idle = 1;
      end
    end
  end
endmodule : ffr_host_model
`default_nettype wire

// File: bench/ffr_sva.sv
// checker for the ready-status sequence
// assumes one clock mclk and sync reset srst
`timescale 1ns/100ps
`default_nettype none
module ffr_sva (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              cmdValid,
  input wire ffr_pkg::ffr_cmd_e cmdKind,
  input wire logic [7:0]        statusWord,
  input wire logic              writeFault
);
  import ffr_pkg::*;
  logic p1, p2;
  // ready held three cycles marks genuine ready
  always_ff @(posedge mclk) {p2, p1} <= {p1, statusWord[0]};
  wire rdy = statusWord[0];
  wire gen = rdy & p1 & p2;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_read_seq: assert property (gen && cmdValid && cmdKind == CMD_READ |=>
    !rdy ##1 rdy [*2] ##1 !rdy [*2] ##1 rdy) else $error("read ready sequence wrong");
  a_write_seq: assert property (gen && cmdValid && cmdKind == CMD_WRITE |=>
    !rdy ##1 rdy [*2] ##1 !rdy [*8] ##1 rdy) else $error("write ready sequence wrong");
  a_ready_holds: assert property (gen && !cmdValid |=> rdy) else $error("ready lost");
  a_upper_zero: assert property (statusWord[7:1] == 7'h0) else $error("status bits set");
  a_read_nofault: assert property (gen && cmdValid && cmdKind == CMD_READ |=> !writeFault)
    else $error("read faulted");
endmodule : ffr_sva
bind flash_ready_status_quirk ffr_sva i_sva (.mclk(mclk), .srst(srst), .cmdValid(cmdValid),
  .cmdKind(cmdKind), .statusWord(statusWord), .writeFault(writeFault));
`default_nettype wire

// File: bench/testbench.sv
// table of {fault, kind, range} rows run through the host model
// assumes design, model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ffr_pkg::*;
  logic mclk, srst, go, cmdValid, freqWrite, idle, writeFault;
  ffr_cmd_e kind, cmdKind;
  logic [7:0] freq, freqSet, statusWord, freqRangeNow;
  int miscompares = 0, total_checks = 0, cyc = 0;
  logic [10:0] rows [4] = '{11'h107, 11'h20F, 11'h13C, 11'h607};
  flash_ready_status_quirk i_dut (.mclk(mclk), .srst(srst), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .freqWrite(freqWrite), .flash_freq_range_setting(freqSet), .statusWord(statusWord),
    .freqRangeNow(freqRangeNow), .writeFault(writeFault));
  ffr_host_model i_host (.mclk(mclk), .srst(srst), .go(go), .kind(kind), .freq(freq),
    .statusWord(statusWord), .cmdValid(cmdValid), .cmdKind(cmdKind), .freqWrite(freqWrite),
    .freqSet(freqSet), .idle(idle));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // clock and hang guard
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      miscompares++;
      end_sim();
    end
  end
  // table loop, then reset after a faulted write
  initial begin
    {srst, go, freq} = 10'h200;
    kind = CMD_NONE;
    repeat (4) @(posedge mclk);
    #1 srst = 0;
    foreach (rows[i]) begin
      @(posedge mclk) #1 go = 1;
      kind = ffr_cmd_e'(rows[i][9:8]);
      freq = rows[i][7:0];
      @(posedge mclk) #1 go = 0;
      repeat (2) @(posedge mclk);
      @(posedge mclk iff idle) #1 chk(statusWord, 8'h01);
      chk(freqRangeNow, rows[i][7:0]);
      chk({7'h0, writeFault}, {7'h0, rows[i][10]});
    end
    srst = 1;
    @(posedge mclk) #1 chk(freqRangeNow, 8'h07);
    chk({7'h0, writeFault}, 8'h00);
    chk(statusWord, 8'h01);
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// File: src/ffr_cfg.svh
// ffr_cfg.svh: constants for the flash ready-status model
// assumes inclusion by bare name from the package and design files
`ifndef FFR_CFG_SVH
`define FFR_CFG_SVH
`define FFR_READY_BIT      0
`define FFR_FREQ_DEFAULT   8'h07
`define FFR_FREQ_WRITE_OK  8'h0F
`define FFR_STATUS_W       8
`define FFR_FALSE_CYC      4'h2
`define FFR_READ_CYC       4'h4
`define FFR_WRITE_CYC      4'hA
`define FFR_FALSE_GAP      4'h2
`define FFR_CNT_ZERO       4'h0
`define FFR_CNT_ONE        4'h1
`endif

// File: src/ffr_op_if.sv
// ffr_op_if.sv: operation handshake between sequencer and array timer
// assumes one clock domain, mclk
`timescale 1ns/100ps
`default_nettype none
interface ffr_op_if;
  import ffr_pkg::*;
  logic     start;
  ffr_cnt_t len;
  logic     done;
  modport seq (output start, output len, input done);
  modport tmr (input start, input len, output done);
endinterface : ffr_op_if
`default_nettype wire

// File: src/ffr_op_timer.sv
// ffr_op_timer.sv: counts out the busy time of one array operation
// assumes start is a one-cycle pulse from the sequencer on mclk
`timescale 1ns/100ps
`default_nettype none
`include "ffr_cfg.svh"
module ffr_op_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // operation handshake
  ffr_op_if.tmr    op
);
  import ffr_pkg::*;
  ffr_cnt_t cnt_r;
  logic     busy_r;
  logic     done_r;
  wire logic lastCycle = busy_r && (cnt_r == `FFR_CNT_ONE);
  assign op.done = done_r;
  // load on start, count down, pulse done at the end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r  <= `FFR_CNT_ZERO;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= lastCycle;
      if (op.start) begin
        cnt_r  <= op.len;
        busy_r <= 1'b1;
      end else if (lastCycle) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r  <= cnt_r - `FFR_CNT_ONE;
      end
    end
  end
endmodule : ffr_op_timer
`default_nettype wire

// File: src/ffr_pkg.sv
// ffr_pkg.sv: types for the flash ready-status model
// assumes ffr_cfg.svh is on the include path
`include "ffr_cfg.svh"
package ffr_pkg;
  typedef enum logic [1:0] {CMD_NONE = 2'h0, CMD_READ = 2'h1, CMD_WRITE = 2'h2} ffr_cmd_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_BUSY1 = 3'h1,
    ST_FALSE = 3'h3,
    ST_BUSY2 = 3'h2,
    ST_DONE  = 3'h6
  } ffr_state_e;
  typedef logic [3:0] ffr_cnt_t;
endpackage : ffr_pkg

// File: src/flash_ready_status_quirk.sv
// flash_ready_status_quirk.sv: command-ready status of an embedded flash controller
// assumes host logic on mclk issues commands and polls statusWord
//
// Summary of operation
// - status bit 0 reports ready for next function
// - first ready after a command is false
// - next ready assertion after that is genuine
// - reads work at any frequency range setting
`timescale 1ns/100ps
`default_nettype none
`include "ffr_cfg.svh"
module flash_ready_status_quirk (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        srst,
  // command port from host logic
  input  wire logic                        cmdValid,
  input  wire ffr_pkg::ffr_cmd_e           cmdKind,
  // frequency-range setting from host
  input  wire logic                        freqWrite,
  input  wire logic [`FFR_STATUS_W-1:0]    flash_freq_range_setting,
  // status toward host
  output logic      [`FFR_STATUS_W-1:0]    statusWord,
  output logic      [`FFR_STATUS_W-1:0]    freqRangeNow,
  output logic                             writeFault
);
  import ffr_pkg::*;

  ffr_state_e                 state_r;
  ffr_state_e                 state_nxt;
  logic [`FFR_STATUS_W-1:0]   freq_r;
  logic                       fault_r;
  logic                       curWrite_r;
  ffr_cnt_t                   gap_r;
  ffr_op_if                   opBus ();

  // array timer models the true busy time
  ffr_op_timer u_timer (
    .mclk (mclk),
    .srst (srst),
    .op   (opBus.tmr)
  );

  function automatic ffr_cnt_t op_len(input logic isWrite);
    op_len = isWrite ? `FFR_WRITE_CYC : `FFR_READ_CYC;
  endfunction : op_len

  // command acceptance and decode
  wire logic idleNow   = (state_r == ST_IDLE) || (state_r == ST_DONE);
  wire logic cmdTake   = cmdValid && idleNow && (cmdKind != CMD_NONE);
  wire logic isWrite   = (cmdKind == CMD_WRITE);
  wire logic freqOk    = (freq_r == `FFR_FREQ_WRITE_OK);
  wire logic falseEnd  = (gap_r == `FFR_CNT_ONE);
  wire logic readyBit  = (state_nxt == ST_FALSE) || (state_nxt == ST_DONE) || (state_nxt == ST_IDLE);
  assign opBus.start = cmdTake;
  assign opBus.len   = op_len(cmdTake && isWrite);

  // next-state: busy, one false ready blip, busy again, then genuine ready
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (cmdTake) state_nxt = ST_BUSY1;
      ST_BUSY1: state_nxt = ST_FALSE;
      ST_FALSE: if (falseEnd) state_nxt = ST_BUSY2;
      ST_BUSY2: if (opBus.done) state_nxt = ST_DONE;
      ST_DONE:  if (cmdTake) state_nxt = ST_BUSY1;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // state and false-ready gap counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      gap_r   <= `FFR_CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      gap_r   <= (state_r == ST_BUSY1) ? `FFR_FALSE_GAP : (gap_r == `FFR_CNT_ZERO ? gap_r : gap_r - `FFR_CNT_ONE);
    end
  end

  // frequency range register; reads ignore it, writes need the raised value
  always_ff @(posedge mclk) begin
    if (srst) begin
      freq_r     <= `FFR_FREQ_DEFAULT;
      fault_r    <= 1'b0;
      curWrite_r <= 1'b0;
    end else begin
      if (freqWrite) freq_r <= flash_freq_range_setting;
      if (cmdTake) begin
        curWrite_r <= isWrite;
        fault_r    <= isWrite && !freqOk;
      end
    end
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      statusWord   <= {`FFR_STATUS_W{1'b0}} | (`FFR_STATUS_W'(1) << `FFR_READY_BIT);
      freqRangeNow <= `FFR_FREQ_DEFAULT;
      writeFault   <= 1'b0;
    end else begin
      statusWord   <= `FFR_STATUS_W'(readyBit) << `FFR_READY_BIT;
      freqRangeNow <= freqWrite ? flash_freq_range_setting : freq_r;
      writeFault   <= (cmdTake ? (isWrite && !freqOk) : fault_r) && (cmdTake ? isWrite : curWrite_r);
    end
  end
endmodule : flash_ready_status_quirk
`default_nettype wire
